// ==== hw/synth_regs_pkg.sv ====
/*
 Constants, field layouts and carrier types for the synthesizer control
 register words 2 and 3. Assumes a 32-bit serial word with address in 2:0.
*/
package synth_regs_pkg;
    localparam int WORD_W = 32;
    localparam logic [2:0] ADDR_WORD0 = 3'h0;
    localparam logic [2:0] ADDR_LOOP = 3'h2;
    localparam logic [2:0] ADDR_BAND = 3'h3;
    localparam logic [31:0] LOOP_RESET = 32'h0000_4042;
    localparam logic [31:0] BAND_RESET = 32'h0000_000b;
    localparam int DBUF_BIT = 13;
    localparam int PUMP_HI = 12;
    localparam int PUMP_LO = 9;
    localparam int LDF_BIT = 8;
    localparam int PDP_BIT = 6;
    localparam int TRI_BIT = 4;
    localparam int CCLR_BIT = 3;
    localparam int OSC_HI = 31;
    localparam int OSC_LO = 26;
    localparam int ABS_OFF_BIT = 25;
    localparam int RETUNE_BIT = 24;
    localparam int CDM_HI = 16;
    localparam int CDM_LO = 15;
    localparam int CDIV_HI = 14;
    localparam int CDIV_LO = 3;
    localparam logic [1:0] CDM_OFF = 2'h0;
    localparam logic [1:0] CDM_FAST = 2'h1;
    localparam logic [1:0] CDM_PHASE = 2'h2;
    localparam logic [11:0] CDIV_ZERO = 12'h000;

    typedef struct packed {
        logic double_buffer_enable;
        logic [3:0] pump_current_code;
        logic lock_detect_function_sel;
        logic phase_detector_polarity;
        logic pump_tristate;
        logic counter_clear;
    } loop_cfg_t;

    typedef struct packed {
        logic [5:0] osc_band_sel;
        logic auto_band_select_off;
        logic temp_retune_enable;
        logic [1:0] clk_div_mode;
        logic [11:0] clk_div_value;
    } band_cfg_t;
endpackage

// ==== hw/synth_ctrl_regs_two_three.sv ====
/*
 Register logic for loop config word (2) and band/clock-divider word (3).
 Assumes the serial front end delivers a completed 32-bit word with a
 one-cycle strobe, synchronous to clk_sys.
*/
`timescale 1ns/10ps
module synth_ctrl_regs_two_three (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Completed serial word
    input wire logic word_valid,
    input wire logic [synth_regs_pkg::WORD_W-1:0] word_data,
    // Applied configuration
    output synth_regs_pkg::loop_cfg_t loop_cfg,
    output synth_regs_pkg::band_cfg_t band_cfg,
    output logic [5:0] active_band,
    output logic band_manual,
    output logic clk_div_bad
);
    import synth_regs_pkg::*;

    logic [2:0] addr;
    logic wr_loop;
    logic wr_band;
    logic wr_zero;
    logic [3:0] pump_code_q;
    loop_cfg_t loop_q;
    loop_cfg_t loop_d;
    band_cfg_t band_q;

    assign addr = word_data[2:0];
    assign wr_loop = word_valid && (addr == ADDR_LOOP);
    assign wr_band = word_valid && (addr == ADDR_BAND);
    assign wr_zero = word_valid && (addr == ADDR_WORD0);

    // Word 2 image; its pump field is the staged code
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            loop_q.double_buffer_enable <= LOOP_RESET[DBUF_BIT];
            loop_q.pump_current_code <= LOOP_RESET[PUMP_HI:PUMP_LO];
            loop_q.lock_detect_function_sel <= LOOP_RESET[LDF_BIT];
            loop_q.phase_detector_polarity <= LOOP_RESET[PDP_BIT];
            loop_q.pump_tristate <= LOOP_RESET[TRI_BIT];
            loop_q.counter_clear <= LOOP_RESET[CCLR_BIT];
        end else if (wr_loop) begin
            loop_q.double_buffer_enable <= word_data[DBUF_BIT];
            loop_q.pump_current_code <= word_data[PUMP_HI:PUMP_LO];
            loop_q.lock_detect_function_sel <= word_data[LDF_BIT];
            loop_q.phase_detector_polarity <= word_data[PDP_BIT];
            loop_q.pump_tristate <= word_data[TRI_BIT];
            loop_q.counter_clear <= word_data[CCLR_BIT];
        end
    end

    // Applied pump code: copied from the staged code on a word 0 write
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pump_code_q <= LOOP_RESET[PUMP_HI:PUMP_LO];
        end else if (wr_zero) begin
            pump_code_q <= loop_q.pump_current_code;
        end
    end

    // Applied word 2 view
    always_comb begin
        loop_d = loop_q;
        loop_d.pump_current_code = pump_code_q;
    end

    // Word 3 fields
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            band_q <= '{osc_band_sel: BAND_RESET[OSC_HI:OSC_LO],
                        auto_band_select_off: BAND_RESET[ABS_OFF_BIT],
                        temp_retune_enable: BAND_RESET[RETUNE_BIT],
                        clk_div_mode: BAND_RESET[CDM_HI:CDM_LO],
                        clk_div_value: BAND_RESET[CDIV_HI:CDIV_LO]};
        end else if (wr_band) begin
            band_q.osc_band_sel <= word_data[OSC_HI:OSC_LO];
            band_q.auto_band_select_off <= word_data[ABS_OFF_BIT];
            band_q.temp_retune_enable <= word_data[RETUNE_BIT];
            band_q.clk_div_mode <= word_data[CDM_HI:CDM_LO];
            band_q.clk_div_value <= word_data[CDIV_HI:CDIV_LO];
        end
    end

    // Applied loop configuration
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            loop_cfg <= '0;
        end else begin
            loop_cfg <= loop_d;
        end
    end

    // Applied band configuration
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            band_cfg <= '0;
        end else begin
            band_cfg <= band_q;
        end
    end

    // Manual band flag
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            band_manual <= 1'b0;
        end else begin
            band_manual <= band_q.auto_band_select_off;
        end
    end

    // Band in use while automatic selection is off
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            active_band <= '0;
        end else begin
            active_band <= band_q.auto_band_select_off ? band_q.osc_band_sel : '0;
        end
    end

    // Divider mode set with a zero ratio
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            clk_div_bad <= 1'b0;
        end else begin
            clk_div_bad <= (band_q.clk_div_mode != CDM_OFF)
                && (band_q.clk_div_value == CDIV_ZERO);
        end
    end

    // Word 2 checks, followed by three word 3 checks
    a_pump_waits_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !$past(wr_zero) |-> $stable(pump_code_q))
        else $error("pump code changed without word 0 write");
    a_pump_takes_pend: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_zero |=> pump_code_q == $past(loop_q.pump_current_code))
        else $error("pump code not taken on word 0");
    a_stage_pump_code: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_loop |=> loop_q.pump_current_code == $past(word_data[PUMP_HI:PUMP_LO]))
        else $error("pump code not staged");
    a_loop_ldf_store: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_loop |=> loop_q.lock_detect_function_sel == $past(word_data[LDF_BIT]))
        else $error("lock detect select not stored");
    a_dbuf_hold_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !wr_loop |=> $stable(loop_q))
        else $error("word 2 image changed without its address");
    a_loop_out_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $past(reset_n) |-> loop_cfg == $past(loop_d))
        else $error("loop output does not follow applied fields");
    a_loop_write_ldf: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_loop |-> ##2 loop_cfg.lock_detect_function_sel == $past(word_data[LDF_BIT], 2))
        else $error("lock detect select not applied");
    a_loop_write_pdp: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_loop |=> loop_q.phase_detector_polarity == $past(word_data[PDP_BIT]))
        else $error("polarity not stored");
    a_tri_clear_dbuf: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_loop |=> loop_q.pump_tristate == $past(word_data[TRI_BIT])
            && loop_q.counter_clear == $past(word_data[CCLR_BIT])
            && loop_q.double_buffer_enable == $past(word_data[DBUF_BIT]))
        else $error("loop control bits not stored");
    a_loop_hold_other: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !wr_loop |=> $stable(loop_q.counter_clear))
        else $error("counter clear changed without word 2 write");
    a_band_manual_sel: assert property (@(posedge clk_sys) disable iff (!reset_n)
        band_manual |-> active_band == $past(band_q.osc_band_sel))
        else $error("manual band not applied");
    a_band_write_store: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_band |=> band_q.clk_div_value == $past(word_data[CDIV_HI:CDIV_LO])
            && band_q.clk_div_mode == $past(word_data[CDM_HI:CDM_LO])
            && band_q.temp_retune_enable == $past(word_data[RETUNE_BIT]))
        else $error("word 3 fields not stored");
    a_band_hold_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !wr_band |=> $stable(band_q))
        else $error("word 3 changed without its address");

    // Word 3 checks
    a_band_osc_store: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_band |=> band_q.osc_band_sel == $past(word_data[OSC_HI:OSC_LO])
            && band_q.auto_band_select_off == $past(word_data[ABS_OFF_BIT]))
        else $error("band select fields not stored");
    a_band_auto_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !band_manual |-> active_band == '0)
        else $error("band shown while automatic selection is on");
    a_band_flag_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $past(reset_n) |-> band_manual == $past(band_q.auto_band_select_off))
        else $error("manual band flag wrong");
    a_band_out_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $past(reset_n) |-> band_cfg == $past(band_q))
        else $error("band output does not follow stored word");
    a_div_mode_store: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_band |=> band_q.clk_div_mode == $past(word_data[CDM_HI:CDM_LO]))
        else $error("divider mode not stored");
    a_div_zero_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $past(reset_n) |-> clk_div_bad == $past((band_q.clk_div_mode != CDM_OFF)
            && (band_q.clk_div_value == CDIV_ZERO)))
        else $error("divider zero flag wrong");
endmodule

// ==== tb/host_word_src.sv ====
/*
 Host side model: hands completed 32-bit words to the register logic.
 Assumes a one-cycle strobe on clk_sys; idle data shows the inverse word.
*/
`timescale 1ns/10ps
module host_word_src (
    // Clock
    input wire logic clk_sys,
    // Completed word
    output logic word_valid,
    output logic [synth_regs_pkg::WORD_W-1:0] word_data
);
    import synth_regs_pkg::*;
    initial begin
        word_valid = 1'b0;
        word_data = 32'h0000_0000;
    end
    task send(input logic [31:0] w);
        logic [31:0] v;
        v = w;
        if (w[2:0] == ADDR_BAND) begin
            v[23:17] = 7'h00;
        end
        @(posedge clk_sys);
        word_valid <= 1'b1;
        word_data <= v;
        @(posedge clk_sys);
        word_valid <= 1'b0;
        word_data <= ~v;
    endtask
endmodule

// ==== tb/tb_synth_ctrl_regs_two_three.sv ====
/*
 Self-checking bench for the word 2 and word 3 register logic.
 Assumes the host model above and two-edge output latency.
*/
`timescale 1ns/10ps
module tb_synth_ctrl_regs_two_three;
    import synth_regs_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic word_valid;
    logic [WORD_W-1:0] word_data;
    loop_cfg_t loop_cfg;
    band_cfg_t band_cfg;
    logic [5:0] active_band;
    logic band_manual;
    logic clk_div_bad;
    int miscompares = 0;
    int checks_done = 0;
    always #20 clk_sys = ~clk_sys;
    host_word_src HOST (.clk_sys(clk_sys), .word_valid(word_valid), .word_data(word_data));
    synth_ctrl_regs_two_three DUT (.clk_sys(clk_sys), .reset_n(reset_n),
        .word_valid(word_valid), .word_data(word_data), .loop_cfg(loop_cfg),
        .band_cfg(band_cfg), .active_band(active_band), .band_manual(band_manual),
        .clk_div_bad(clk_div_bad));
    function automatic loop_cfg_t exp_loop(logic [31:0] w, logic [3:0] pump);
        return loop_cfg_t'{w[DBUF_BIT], pump, w[LDF_BIT], w[PDP_BIT], w[TRI_BIT], w[CCLR_BIT]};
    endfunction
    function automatic band_cfg_t exp_band(logic [31:0] w);
        return band_cfg_t'{w[31:26], w[25], w[24], w[16:15], w[14:3]};
    endfunction
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task settle;
        @(posedge clk_sys);
        #1;
    endtask
    task band_check(input logic [31:0] w);
        check("band_cfg", band_cfg, exp_band(w));
        check("active_band", active_band, w[25] ? w[31:26] : 6'h00);
        check("band_manual", band_manual, w[25]);
        check("clk_div_bad", clk_div_bad, (w[16:15] != 2'h0) && (w[14:3] == 12'h000));
    endtask
    task reset_check;
        check("loop_cfg", loop_cfg, exp_loop(LOOP_RESET, LOOP_RESET[12:9]));
        band_check(BAND_RESET);
    endtask
    task do_reset;
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        reset_check();
    endtask
    task unmapped_words;
        for (int a = 1; a < 8; a++) begin
            if (a != 2 && a != 3) begin
                HOST.send({29'h1fff_ffff, 3'(a)});
            end
        end
        settle();
        reset_check();
    endtask
    task loop_word(input logic [31:0] w, input logic [3:0] held);
        HOST.send(w);
        settle();
        check("loop_cfg", loop_cfg, exp_loop(w, held));
        HOST.send({w[LDF_BIT], 28'h000_0000, ADDR_WORD0});
        settle();
        check("loop_cfg", loop_cfg, exp_loop(w, w[PUMP_HI:PUMP_LO]));
    endtask
    task band_words;
        logic [31:0] w;
        for (int i = 0; i < 4; i++) begin
            w = {6'h3f - 6'(i), i[0], i[1], 7'h7f, 2'(i), i[0] ? 12'hfff : 12'h000, ADDR_BAND};
            HOST.send(w);
            settle();
            band_check(w);
        end
    endtask
    task results;
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        unmapped_words();
        loop_word(32'h0000_0b1a, LOOP_RESET[12:9]);
        loop_word(32'h0000_3e42, 4'h5);
        band_words();
        do_reset();
        results();
    end
endmodule
